/* logic/lvdc_consts.svh */
`ifndef LVDC_CONSTS_SVH
`define LVDC_CONSTS_SVH

`define LVDC_ADDR_DETECT    32'h4007D000
`define LVDC_ADDR_WARNING   32'h4007D001
`define LVDC_ADDR_REGULATOR 32'h4007D002

`define LVDC_RST_DETECT     8'h10
`define LVDC_RST_WARNING    8'h00
`define LVDC_RST_REGULATOR  8'h04

`define LVDC_BIT_FLAG       7
`define LVDC_BIT_CLEAR      6
`define LVDC_BIT_IRQ_EN     5
`define LVDC_BIT_RESET_EN   4
`define LVDC_BIT_ISO_ACK    3
`define LVDC_BIT_REG_ON     2
`define LVDC_SEL_HI         1
`define LVDC_SEL_LO         0

`define LVDC_TRIP_LOW       2'h0
`define LVDC_TRIP_HIGH      2'h1
`define LVDC_SEL_RESET      2'h0

`endif

/* logic/lvdc_pkg.sv */
package lvdc_pkg;

  // power mode reported by the mode controller
  typedef enum logic [1:0]
  {
    LVDC_MODE_RUN,
    LVDC_MODE_VLP,
    LVDC_MODE_LLS,
    LVDC_MODE_VLLS
  } lvdc_mode_t;

  // why the pins are currently held
  typedef enum logic [1:0]
  {
    LVDC_HOLD_NONE,
    LVDC_HOLD_LLS,
    LVDC_HOLD_VLLS
  } lvdc_hold_t;

endpackage : lvdc_pkg

/* logic/lvdc_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module lvdc_sync
#(
  parameter int WIDTH = 2
)
(
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // no reset: comparator levels are simply resampled after reset
  always_ff @(posedge clk)
  begin
    meta_reg <= async_in;
    sync_out <= meta_reg;
  end

endmodule : lvdc_sync

`default_nettype wire

/* logic/lvdc_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "lvdc_consts.svh"

module lvdc_top
  import lvdc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        por_rst,
  input  wire logic        reg_en,
  input  wire logic        reg_wr,
  input  wire logic [31:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_supervisor,
  input  wire logic        below_detect_raw,
  input  wire logic        below_warning_raw,
  input  wire logic        regulator_run_raw,
  input  wire lvdc_mode_t  power_mode,
  output logic             reg_ack,
  output logic [7:0]       reg_rdata,
  output logic             reg_bus_error,
  output logic             detect_trip_high,
  output logic [1:0]       warning_level,
  output logic             detect_irq,
  output logic             warning_irq,
  output logic             chip_reset_req,
  output logic             reset_cause_low_supply,
  output logic             io_hold
);

  // comparator and regulator levels come from analog, another domain
  logic [2:0] sync_levels;

  lvdc_sync #(.WIDTH(3)) u_sync
  (
    .clk      (clk),
    .async_in ({regulator_run_raw, below_warning_raw, below_detect_raw}),
    .sync_out (sync_levels)
  );

  wire below_detect  = sync_levels[0];
  wire below_warning = sync_levels[1];
  wire regulator_run = sync_levels[2];

  // control state
  logic       detect_flag_reg;
  logic       detect_irq_enable_reg;
  logic       detect_reset_enable_reg;
  logic       reset_enable_written_reg;
  logic [1:0] detect_trip_select_reg;
  logic       warning_flag_reg;
  logic       warning_irq_enable_reg;
  logic [1:0] warning_trip_select_reg;
  lvdc_hold_t hold_reg;

  // reset image of the detect register, sliced per bit below
  wire [7:0] rst_detect = `LVDC_RST_DETECT;

  // acknowledge only counts once the comparator has let go
  function automatic logic ack_clear
  (
    input logic       wr,
    input logic [7:0] data,
    input logic       below
  );
    ack_clear = wr && data[`LVDC_BIT_CLEAR] && !below;
  endfunction : ack_clear

  // level flag: the set side wins over a same-cycle clear
  function automatic logic flag_update
  (
    input logic set,
    input logic cur,
    input logic clr
  );
    flag_update = set || (cur && !clr);
  endfunction : flag_update

  // write-enable mux shared by the reset and interrupt enable bits
  function automatic logic bit_update
  (
    input logic wr,
    input logic val,
    input logic cur
  );
    bit_update = wr ? val : cur;
  endfunction : bit_update

  // bus decode
  wire hit_detect  = (reg_addr == `LVDC_ADDR_DETECT);
  wire hit_warning = (reg_addr == `LVDC_ADDR_WARNING);
  wire hit_reg     = (reg_addr == `LVDC_ADDR_REGULATOR);
  wire wr_any      = reg_en && reg_wr;
  wire wr_ok       = wr_any && reg_supervisor;
  wire wr_user     = wr_any && !reg_supervisor;
  wire wr_detect   = wr_ok && hit_detect;
  wire wr_warning  = wr_ok && hit_warning;
  wire wr_regul    = wr_ok && hit_reg;

  wire detect_on = (power_mode == LVDC_MODE_RUN);

  wire detect_set   = detect_on && below_detect;
  wire detect_clr   = ack_clear(wr_detect, reg_wdata, below_detect);
  wire warning_set  = detect_on && below_warning;
  wire warning_clr  = ack_clear(wr_warning, reg_wdata, below_warning);

  wire detect_flag_next  = flag_update(detect_set, detect_flag_reg, detect_clr);
  wire warning_flag_next = flag_update(warning_set, warning_flag_reg, warning_clr);

  wire re_write = wr_detect && !reset_enable_written_reg;
  wire detect_reset_enable_next = bit_update(re_write,
                                             reg_wdata[`LVDC_BIT_RESET_EN],
                                             detect_reset_enable_reg);
  wire detect_irq_enable_next   = bit_update(wr_detect,
                                             reg_wdata[`LVDC_BIT_IRQ_EN],
                                             detect_irq_enable_reg);
  wire warning_irq_enable_next  = bit_update(wr_warning,
                                             reg_wdata[`LVDC_BIT_IRQ_EN],
                                             warning_irq_enable_reg);

  // request reset; held while supply stays below, rst does not cut it
  // next enable, so request and interrupt never overlap on the first write
  wire chip_reset_req_next = detect_reset_enable_next && detect_set;

  // interrupt only when reset path is off; level flag and enable
  wire detect_irq_next  = detect_flag_next && detect_irq_enable_next
                          && !detect_reset_enable_next;
  // warning interrupt; level flag and enable
  wire warning_irq_next = warning_flag_next && warning_irq_enable_next;

  wire iso_ack = wr_regul && reg_wdata[`LVDC_BIT_ISO_ACK];
  lvdc_hold_t hold_next;
  always_comb
  begin
    hold_next = hold_reg;
    case (hold_reg)
      LVDC_HOLD_NONE:
      begin
        if (power_mode == LVDC_MODE_LLS)
          hold_next = LVDC_HOLD_LLS;
        else if (power_mode == LVDC_MODE_VLLS)
          hold_next = LVDC_HOLD_VLLS;
      end
      LVDC_HOLD_LLS:
      begin
        if (power_mode != LVDC_MODE_LLS)
          hold_next = LVDC_HOLD_NONE;
      end
      LVDC_HOLD_VLLS:
      begin
        if (power_mode != LVDC_MODE_VLLS && iso_ack)
          hold_next = LVDC_HOLD_NONE;
      end
      default:
        hold_next = LVDC_HOLD_NONE;
    endcase
  end

  // read data; clear bits read zero; layout
  wire [7:0] rd_detect = {detect_flag_reg, 1'b0, detect_irq_enable_reg,
                          detect_reset_enable_reg, 2'h0, detect_trip_select_reg};
  wire [7:0] rd_warning = {warning_flag_reg, 1'b0, warning_irq_enable_reg,
                           3'h0, warning_trip_select_reg};
  wire       holding_vlls = (hold_reg == LVDC_HOLD_VLLS);
  wire [7:0] rd_regul = {4'h0, holding_vlls, regulator_run, 2'h0};
  wire [7:0] rd_mux = hit_detect  ? rd_detect  :
                      hit_warning ? rd_warning :
                      hit_reg     ? rd_regul   : 8'h00;

  wire       detect_trip_high_next = (detect_trip_select_reg == `LVDC_TRIP_HIGH);

  // trip selects survive every reset but power-on
  always_ff @(posedge clk)
  begin
    if (por_rst)
    begin
      detect_trip_select_reg  <= `LVDC_SEL_RESET;
      warning_trip_select_reg <= `LVDC_SEL_RESET;
      detect_trip_high        <= 1'b0;
      warning_level           <= `LVDC_SEL_RESET;
    end
    else
    begin
      if (wr_detect)
        detect_trip_select_reg <= reg_wdata[`LVDC_SEL_HI:`LVDC_SEL_LO];
      if (wr_warning)
        warning_trip_select_reg <= reg_wdata[`LVDC_SEL_HI:`LVDC_SEL_LO];
      detect_trip_high <= detect_trip_high_next;
      warning_level    <= warning_trip_select_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (por_rst || rst)
    begin
      detect_flag_reg          <= rst_detect[`LVDC_BIT_FLAG];
      detect_irq_enable_reg    <= rst_detect[`LVDC_BIT_IRQ_EN];
      detect_reset_enable_reg  <= rst_detect[`LVDC_BIT_RESET_EN];
      reset_enable_written_reg <= 1'b0;
      warning_flag_reg         <= 1'b0;
      warning_irq_enable_reg   <= 1'b0;
      detect_irq               <= 1'b0;
      warning_irq              <= 1'b0;
    end
    else
    begin
      detect_flag_reg          <= detect_flag_next;
      detect_irq_enable_reg    <= detect_irq_enable_next;
      detect_reset_enable_reg  <= detect_reset_enable_next;
      reset_enable_written_reg <= reset_enable_written_reg || wr_detect;
      warning_flag_reg         <= warning_flag_next;
      warning_irq_enable_reg   <= warning_irq_enable_next;
      detect_irq               <= detect_irq_next;
      warning_irq              <= warning_irq_next;
    end
  end

  // reset request and its cause live through the reset they start
  always_ff @(posedge clk)
  begin
    if (por_rst)
    begin
      chip_reset_req         <= 1'b0;
      reset_cause_low_supply <= 1'b1;
    end
    else
    begin
      chip_reset_req <= chip_reset_req_next;
      if (chip_reset_req)
        reset_cause_low_supply <= 1'b1;
      else if (rst)
        reset_cause_low_supply <= 1'b0;
    end
  end

  // pin hold: a reset-pin exit arrives as rst and releases
  always_ff @(posedge clk)
  begin
    if (por_rst || rst)
    begin
      hold_reg <= LVDC_HOLD_NONE;
      io_hold  <= 1'b0;
    end
    else
    begin
      hold_reg <= hold_next;
      io_hold  <= (hold_next != LVDC_HOLD_NONE);
    end
  end

  // bus answer one cycle after the request
  always_ff @(posedge clk)
  begin
    if (por_rst || rst)
    begin
      reg_ack       <= 1'b0;
      reg_rdata     <= 8'h00;
      reg_bus_error <= 1'b0;
    end
    else
    begin
      reg_ack       <= reg_en;
      reg_rdata     <= (reg_en && !reg_wr) ? rd_mux : 8'h00;
      reg_bus_error <= wr_user;
    end
  end

endmodule : lvdc_top

`default_nettype wire

/* testbench/low_voltage_detect_control_bench.sv */
`timescale 1ns/10ps
`default_nettype none

module low_voltage_detect_control_bench
  import lvdc_pkg::*;
;
  logic        clk, rst, por_rst, reg_en, reg_wr, reg_supervisor;
  logic        below_detect_raw, below_warning_raw, regulator_run_raw;
  logic [31:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  lvdc_mode_t  power_mode;
  logic        reg_ack, reg_bus_error, detect_trip_high, detect_irq, warning_irq;
  logic        chip_reset_req, reset_cause_low_supply, io_hold;
  logic [1:0]  warning_level;
  int          fail_count, total_checks;

  lvdc_top uut (.clk, .rst, .por_rst, .reg_en, .reg_wr, .reg_addr, .reg_wdata,
    .reg_supervisor, .below_detect_raw, .below_warning_raw, .regulator_run_raw,
    .power_mode, .reg_ack, .reg_rdata, .reg_bus_error, .detect_trip_high,
    .warning_level, .detect_irq, .warning_irq, .chip_reset_req,
    .reset_cause_low_supply, .io_hold);

  task automatic stop_test();
    if (fail_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // one access; user writes must come back with a bus error
  task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d,
                     input logic [7:0] e, input logic s = 1'b1);
    cyc(1);
    reg_en = 1'b1;
    reg_wr = w;
    reg_addr = 32'h4007D000 + 32'(a);
    reg_wdata = d;
    reg_supervisor = s;
    cyc(1);
    reg_en = 1'b0;
    chk(reg_ack, 8'h01);
    chk(reg_bus_error, 8'(w & !s));
    if (!w)
      chk(reg_rdata, e);
  endtask : bus

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    #10000;
    fail_count++;
    stop_test();
  end

  initial
  begin
    {rst, por_rst, regulator_run_raw} = 3'h7;
    {reg_en, reg_wr, reg_supervisor, below_detect_raw, below_warning_raw} = 5'h00;
    reg_addr = 32'h0;
    reg_wdata = 8'h00;
    power_mode = LVDC_MODE_RUN;
    fail_count = 0;
    total_checks = 0;
    cyc(10);
    {rst, por_rst} = 2'h0;
    chk(reset_cause_low_supply, 1);
    bus(0, 0, 0, 8'h10);
    bus(0, 1, 0, 8'h00);
    bus(0, 2, 0, 8'h04);
    bus(1, 0, 8'h01, 0);
    bus(0, 0, 0, 8'h01);
    chk(detect_trip_high, 1);
    bus(1, 0, 8'h13, 0);
    bus(0, 0, 0, 8'h03);
    chk(detect_trip_high, 0);
    bus(1, 1, 8'h23, 0, 0);
    bus(0, 1, 0, 8'h00);
    bus(0, 3, 0, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      bus(1, 1, 8'(i), 0);
      bus(0, 1, 0, 8'(i));
      chk(warning_level, 8'(i));
    end
    bus(1, 1, 8'h43, 0);
    bus(1, 1, 8'h23, 0);
    below_warning_raw = 1'b1;
    cyc(4);
    bus(0, 1, 0, 8'hA3);
    chk(warning_irq, 1);
    bus(1, 1, 8'h63, 0);
    bus(0, 1, 0, 8'hA3);
    below_warning_raw = 1'b0;
    cyc(4);
    bus(0, 1, 0, 8'hA3);
    bus(1, 1, 8'h63, 0);
    bus(0, 1, 0, 8'h23);
    chk(warning_irq, 0);
    bus(1, 0, 8'h20, 0);
    below_detect_raw = 1'b1;
    cyc(4);
    bus(0, 0, 0, 8'hA0);
    chk(detect_irq, 1);
    chk(chip_reset_req, 0);
    bus(1, 0, 8'h60, 0);
    bus(0, 0, 0, 8'hA0);
    below_detect_raw = 1'b0;
    cyc(4);
    bus(1, 0, 8'h60, 0);
    bus(0, 0, 0, 8'h20);
    chk(detect_irq, 0);
    power_mode = LVDC_MODE_VLP;
    below_detect_raw = 1'b1;
    cyc(5);
    bus(0, 0, 0, 8'h20);
    below_detect_raw = 1'b0;
    cyc(4);
    power_mode = LVDC_MODE_RUN;
    // select must survive a chip reset
    bus(1, 0, 8'h21, 0);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    bus(0, 0, 0, 8'h11);
    chk(warning_level, 3);
    chk(reset_cause_low_supply, 0);
    below_detect_raw = 1'b1;
    cyc(4);
    chk(chip_reset_req, 1);
    chk(detect_irq, 0);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(2);
    chk(chip_reset_req, 1);
    chk(reset_cause_low_supply, 1);
    below_detect_raw = 1'b0;
    cyc(4);
    chk(chip_reset_req, 0);
    power_mode = LVDC_MODE_LLS;
    cyc(3);
    chk(io_hold, 1);
    power_mode = LVDC_MODE_RUN;
    cyc(3);
    chk(io_hold, 0);
    power_mode = LVDC_MODE_VLLS;
    cyc(3);
    power_mode = LVDC_MODE_RUN;
    cyc(3);
    chk(io_hold, 1);
    bus(0, 2, 0, 8'h0C);
    bus(1, 2, 8'h08, 0);
    cyc(2);
    chk(io_hold, 0);
    power_mode = LVDC_MODE_VLLS;
    cyc(3);
    power_mode = LVDC_MODE_RUN;
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    chk(io_hold, 0);
    stop_test();
  end
endmodule : low_voltage_detect_control_bench

`default_nettype wire

/* testbench/lvdc_sva.sv */
`timescale 1ns/10ps
`default_nettype none

module lvdc_sva
  import lvdc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        por_rst,
  input wire logic        reg_en,
  input wire logic        reg_wr,
  input wire logic [31:0] reg_addr,
  input wire logic        reg_supervisor,
  input wire lvdc_mode_t  power_mode,
  input wire logic        reg_ack,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_bus_error,
  input wire logic        detect_irq,
  input wire logic        warning_irq,
  input wire logic        chip_reset_req,
  input wire logic        reset_cause_low_supply,
  input wire logic        io_hold
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst || por_rst);

  wire rd_det = reg_en && !reg_wr && reg_addr == 32'h4007D000;

  a_ack_follows_req:
    assert property (reg_en |=> reg_ack)
    else $error("bus request not acknowledged");
  a_ack_needs_req:
    assert property (!reg_en |=> !reg_ack)
    else $error("acknowledge without request");
  a_user_write_err:
    assert property (reg_en && reg_wr && !reg_supervisor |=> reg_bus_error)
    else $error("user write not refused");
  a_super_no_err:
    assert property (reg_en && reg_supervisor |=> !reg_bus_error)
    else $error("bus error on supervisor access");
  a_fixed_zero_bits:
    assert property (rd_det |=> reg_rdata[6] == 1'b0 && reg_rdata[3:2] == 2'h0)
    else $error("detect clear or spare bits read nonzero");
  a_lowpwr_no_reset:
    assert property (power_mode != LVDC_MODE_RUN |=> !chip_reset_req)
    else $error("reset request outside run mode");
  a_irq_not_reset:
    assert property (!(detect_irq && chip_reset_req))
    else $error("detect interrupt while reset enabled");
  a_por_sets_cause:
    assert property (disable iff (rst) por_rst |=> reset_cause_low_supply)
    else $error("power-on reset cause not set");
  a_lls_holds_pins:
    assert property (power_mode == LVDC_MODE_LLS [*2] |=> io_hold)
    else $error("pins not held in low-leakage stop");

  c_reset_req: cover property (chip_reset_req);
  c_detect_irq: cover property (detect_irq);
  c_warning_irq: cover property (warning_irq);
endmodule : lvdc_sva

bind lvdc_top lvdc_sva chk_i (.clk, .rst, .por_rst, .reg_en, .reg_wr, .reg_addr,
  .reg_supervisor, .power_mode, .reg_ack, .reg_rdata, .reg_bus_error, .detect_irq,
  .warning_irq, .chip_reset_req, .reset_cause_low_supply, .io_hold);

`default_nettype wire
